/* core/pt16_params.svh */
`ifndef PT16_PARAMS_SVH
`define PT16_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define PT16_OFF_SHARED_CTRL 8'h00
`define PT16_OFF_WIDE_CTRL 8'h04
`define PT16_OFF_RELOAD_HIGH 8'h08
`define PT16_OFF_RELOAD_LOW 8'h0C
`define PT16_OFF_CAPTURE_HIGH 8'h10
`define PT16_OFF_CAPTURE_LOW 8'h14
`define PT16_OFF_EDGE_STATUS 8'h18

// ==========================================================
// Shared control register fields
`define PT16_SH_DEMOD_BIT 6
`define PT16_SH_FALL_SEL_BIT 5
`define PT16_SH_RISE_SEL_BIT 4
`define PT16_SH_OUTSEL_HI 3
`define PT16_SH_OUTSEL_LO 2
`define PT16_SH_WIDE_INIT_BIT 0

// ==========================================================
// Wide control register fields
`define PT16_WC_ENABLE_BIT 7
`define PT16_WC_SINGLE_BIT 6
`define PT16_WC_TIMEOUT_BIT 5
`define PT16_WC_CLK_HI 4
`define PT16_WC_CLK_LO 3
`define PT16_WC_CAPMASK_BIT 2
`define PT16_WC_TOMASK_BIT 1
`define PT16_WC_PINSEL_BIT 0

// ==========================================================
// Edge status register fields
`define PT16_ES_RISE_BIT 1
`define PT16_ES_FALL_BIT 0

// ==========================================================
// Output select codes and constants
`define PT16_OUTSEL_NONE 2'h0
`define PT16_OUTSEL_PINGPONG 2'h1
`define PT16_OUTSEL_FORCE0 2'h2
`define PT16_OUTSEL_FORCE1 2'h3
`define PT16_COUNT_ALL_ONES 16'hFFFF
`define PT16_COUNT_ONE 16'h0001
`define PT16_RESET_BYTE 8'h00
`define PT16_RESET_COUNT 16'h0000

`endif

/* core/pt16_pkg.sv */
package pt16_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_EDGE,
		ST_RUN
	} pt16_state_e;

	typedef logic [15:0] pt16_word_t;

endpackage

/* core/pt16_edge_detect.sv */
`timescale 1ns/1ps

module pt16_edge_detect (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic edgeIn,
	output logic risePulse,
	output logic fallPulse
);

	logic lastReg;
	logic lastNext;
	logic riseReg;
	logic riseNext;
	logic fallReg;
	logic fallNext;

	// ==========================================================
	// Edge pulses
	always_comb begin
		lastNext = edgeIn;
		riseNext = edgeIn & ~lastReg; // RULE23
		fallNext = ~edgeIn & lastReg; // RULE23
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lastReg <= 1'b0;
			riseReg <= 1'b0;
			fallReg <= 1'b0;
		end else begin
			lastReg <= lastNext;
			riseReg <= riseNext;
			fallReg <= fallNext;
		end
	end

	assign risePulse = riseReg;
	assign fallPulse = fallReg;

	chk_edge_single: assert property (@(posedge core_clk) disable iff (!nrst)
		!(riseReg && fallReg)) else $error("rise and fall pulses together"); // RULE23

endmodule

/* core/pt16_timer.sv */
`timescale 1ns/1ps
`include "pt16_params.svh"

// Overview of operation
// (RULE1) Disabled in normal or ping-pong: output is inverse of initial-value bit.
// (RULE2) Output-select 10 forces output 0, 11 forces 1, enabled or not.
// (RULE3) Enable loads high*256+low reload and sets output to initial value.
// (RULE4) Transmit terminal count toggles output, sets time-out flag, masked request.
// (RULE5) At terminal count single-pass stops, modulo-N reloads and keeps counting.
// (RULE6) Reload bytes may change anytime; new value applies at the next load.
// (RULE7) Software never programs an initial count of one.
// (RULE8) Count zero wraps to FFFF without any time-out.
// (RULE9) Software sets both reload bytes to all ones before demodulation.
// (RULE10) Demodulation: first selected edge captures, reloads and starts counting.
// (RULE11) Edges honoured: capture complement, set edge flag, masked request, reload FFFF.
// (RULE12) Edges ignored: narrow time-out captures without reload, masked request.
// (RULE13) Writing ignore bit 0 then 1 rearms one capture-and-reload edge.
// (RULE14) Demodulation zero continues from FFFF, sets time-out flag, masked request.
// (RULE15) Ping-pong only in transmit, both single-pass, started by either enable.
// (RULE16) Ping-pong terminal count disables this counter and enables the other.
// (RULE17) Writing 00 to output-select ends ping-pong operation.
// (RULE18) Software stops counters and clears flags before entering ping-pong.
// (RULE19) In ping-pong hardware toggles enables and sets time-out each terminal count.
// (RULE20) Time-out flag clears only on a written one.
// (RULE21) Two-bit clock field divides the count clock by 1, 2, 4 or 8.
// (RULE22) Routing bit chooses port output or wide output on the pin.
// (RULE23) Edge pulses are one cycle; edge flags clear on a written one.
module pt16_timer (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic edgeIn,
	input wire logic portOut,
	input wire logic narrowTerminal,
	output logic narrowStart,
	output logic timeoutIrq,
	output logic captureIrq,
	output logic wideCounterOutput,
	output logic timerOutputPin
);

	// ==========================================================
	// Declarations
	logic [7:0] shCtrlReg, shCtrlNext;
	logic [6:0] wCtrlReg, wCtrlNext;
	logic timeoutReg, timeoutNext;
	logic [7:0] reloadHiReg, reloadHiNext, reloadLoReg, reloadLoNext;
	logic [7:0] capHiReg, capHiNext, capLoReg, capLoNext;
	logic [1:0] edgeFlagReg, edgeFlagNext;
	pt16_pkg::pt16_word_t countReg, countNext;
	pt16_pkg::pt16_state_e stateReg, stateNext;
	logic outReg, outNext, rearmReg, rearmNext;
	logic [2:0] divReg, divNext;
	logic [31:0] prdataReg, prdataNext;
	logic preadyReg, preadyNext, pslverrReg, pslverrNext;
	logic narrowStartReg, narrowStartNext, toIrqReg, toIrqNext, capIrqReg, capIrqNext;
	logic wideOutReg, wideOutNext, pinReg, pinNext;
	logic risePulse, fallPulse;
	logic wrAccess, demod, pingPong, edgeHit, tick, ignoreEdges, initBit;
	logic [1:0] outSel;
	pt16_pkg::pt16_word_t reloadValue;

	pt16_edge_detect edgeUnit (
		.core_clk(core_clk),
		.nrst(nrst),
		.edgeIn(edgeIn),
		.risePulse(risePulse),
		.fallPulse(fallPulse)
	);

	// Returns the one's complement image of the running count.
	function automatic pt16_pkg::pt16_word_t captureImage(input pt16_pkg::pt16_word_t cnt);
		captureImage = ~cnt;
	endfunction

	// Returns high when the prescaler grants a count step.
	function automatic logic countTick(input logic [1:0] sel, input logic [2:0] div);
		case (sel)
			2'h0: countTick = 1'b1;
			2'h1: countTick = div[0];
			2'h2: countTick = &div[1:0];
			default: countTick = &div;
		endcase
	endfunction

	// ==========================================================
	// Counter, registers and bus
	always_comb begin
		shCtrlNext = shCtrlReg;
		wCtrlNext = wCtrlReg;
		timeoutNext = timeoutReg;
		reloadHiNext = reloadHiReg;
		reloadLoNext = reloadLoReg;
		capHiNext = capHiReg;
		capLoNext = capLoReg;
		edgeFlagNext = edgeFlagReg;
		countNext = countReg;
		stateNext = stateReg;
		outNext = outReg;
		rearmNext = rearmReg;
		narrowStartNext = 1'b0;
		toIrqNext = 1'b0;
		capIrqNext = 1'b0;
		divNext = divReg + 3'h1;
		wrAccess = psel & penable & pwrite & preadyReg;
		demod = shCtrlReg[`PT16_SH_DEMOD_BIT];
		outSel = shCtrlReg[`PT16_SH_OUTSEL_HI:`PT16_SH_OUTSEL_LO];
		pingPong = (outSel == `PT16_OUTSEL_PINGPONG) & ~demod;
		initBit = shCtrlReg[`PT16_SH_WIDE_INIT_BIT];
		ignoreEdges = wCtrlReg[`PT16_WC_SINGLE_BIT];
		edgeHit = (risePulse & shCtrlReg[`PT16_SH_RISE_SEL_BIT]) |
			(fallPulse & shCtrlReg[`PT16_SH_FALL_SEL_BIT]);
		tick = countTick(wCtrlReg[`PT16_WC_CLK_HI:`PT16_WC_CLK_LO], divReg); // RULE21
		reloadValue = {reloadHiReg, reloadLoReg}; // RULE3 RULE6
		// Write-one clears come first so that a same-cycle hardware set wins.
		if (wrAccess && paddr == `PT16_OFF_WIDE_CTRL && pwdata[`PT16_WC_TIMEOUT_BIT]) begin
			timeoutNext = 1'b0; // RULE20
		end
		if (wrAccess && paddr == `PT16_OFF_EDGE_STATUS) begin
			edgeFlagNext = edgeFlagReg & ~pwdata[1:0]; // RULE23
		end
		case (stateReg)
			pt16_pkg::ST_IDLE: begin
				if (pingPong && narrowTerminal) begin
					stateNext = pt16_pkg::ST_RUN; // RULE16 RULE19
					countNext = reloadValue;
					outNext = initBit;
				end
			end
			pt16_pkg::ST_WAIT_EDGE: begin
				if (edgeHit) begin
					{capHiNext, capLoNext} = captureImage(countReg); // RULE10
					countNext = reloadValue;
					rearmNext = 1'b0; // RULE13
					stateNext = pt16_pkg::ST_RUN;
				end
			end
			pt16_pkg::ST_RUN: begin
				if (demod) begin
					if (edgeHit && (!ignoreEdges || rearmReg)) begin
						{capHiNext, capLoNext} = captureImage(countReg); // RULE11
						edgeFlagNext[`PT16_ES_RISE_BIT] = edgeFlagNext[`PT16_ES_RISE_BIT] |
							(risePulse & shCtrlReg[`PT16_SH_RISE_SEL_BIT]);
						edgeFlagNext[`PT16_ES_FALL_BIT] = edgeFlagNext[`PT16_ES_FALL_BIT] |
							(fallPulse & shCtrlReg[`PT16_SH_FALL_SEL_BIT]);
						capIrqNext = wCtrlReg[`PT16_WC_CAPMASK_BIT];
						countNext = `PT16_COUNT_ALL_ONES;
						rearmNext = 1'b0; // RULE13
					end else if (narrowTerminal && ignoreEdges) begin
						{capHiNext, capLoNext} = captureImage(countReg); // RULE12
						capIrqNext = wCtrlReg[`PT16_WC_CAPMASK_BIT];
					end else if (tick) begin
						countNext = countReg - `PT16_COUNT_ONE; // RULE14 RULE8
						if (countReg == `PT16_COUNT_ONE) begin
							timeoutNext = 1'b1; // RULE14
							toIrqNext = wCtrlReg[`PT16_WC_TOMASK_BIT];
						end
					end
				end else if (tick) begin
					if (countReg == `PT16_COUNT_ONE) begin
						outNext = ~outReg; // RULE4
						timeoutNext = 1'b1; // RULE4 RULE19
						toIrqNext = wCtrlReg[`PT16_WC_TOMASK_BIT];
						if (wCtrlReg[`PT16_WC_SINGLE_BIT]) begin
							stateNext = pt16_pkg::ST_IDLE; // RULE5
							narrowStartNext = pingPong; // RULE16 RULE19
						end else begin
							countNext = reloadValue; // RULE5
						end
					end else begin
						countNext = countReg - `PT16_COUNT_ONE; // RULE8
					end
				end
			end
			default: stateNext = pt16_pkg::ST_IDLE;
		endcase
		// Register writes; an enable while running is ignored so the count is not disturbed.
		if (wrAccess) begin
			case (paddr)
				`PT16_OFF_SHARED_CTRL: shCtrlNext = pwdata[7:0]; // RULE17
				`PT16_OFF_RELOAD_HIGH: reloadHiNext = pwdata[7:0]; // RULE6
				`PT16_OFF_RELOAD_LOW: reloadLoNext = pwdata[7:0]; // RULE6
				`PT16_OFF_WIDE_CTRL: begin
					wCtrlNext = pwdata[6:0];
					wCtrlNext[`PT16_WC_TIMEOUT_BIT] = 1'b0;
					if (!pwdata[`PT16_WC_SINGLE_BIT]) begin
						rearmNext = 1'b1; // RULE13
					end
					if (!pwdata[`PT16_WC_ENABLE_BIT]) begin
						stateNext = pt16_pkg::ST_IDLE;
					end else if (stateReg == pt16_pkg::ST_IDLE) begin
						outNext = initBit; // RULE3
						if (demod) begin
							stateNext = pt16_pkg::ST_WAIT_EDGE; // RULE10
						end else begin
							stateNext = pt16_pkg::ST_RUN;
							countNext = reloadValue; // RULE3
						end
					end
				end
				default: begin
				end
			endcase
		end
		// Output path; forcing overrides the counter in every state.
		if (outSel == `PT16_OUTSEL_FORCE0) begin
			wideOutNext = 1'b0; // RULE2
		end else if (outSel == `PT16_OUTSEL_FORCE1) begin
			wideOutNext = 1'b1; // RULE2
		end else if (stateNext == pt16_pkg::ST_IDLE) begin
			wideOutNext = ~shCtrlNext[`PT16_SH_WIDE_INIT_BIT]; // RULE1
		end else begin
			wideOutNext = outNext;
		end
		pinNext = wCtrlNext[`PT16_WC_PINSEL_BIT] ? wideOutNext : portOut; // RULE22
		// Bus answer: data and ready are prepared in the setup cycle.
		preadyNext = psel & ~penable;
		pslverrNext = 1'b0;
		prdataNext = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				`PT16_OFF_SHARED_CTRL: prdataNext[7:0] = shCtrlReg;
				`PT16_OFF_WIDE_CTRL: prdataNext[7:0] = {stateReg != pt16_pkg::ST_IDLE,
					wCtrlReg[6], timeoutReg, wCtrlReg[4:0]};
				`PT16_OFF_RELOAD_HIGH: prdataNext[7:0] = reloadHiReg;
				`PT16_OFF_RELOAD_LOW: prdataNext[7:0] = reloadLoReg;
				`PT16_OFF_CAPTURE_HIGH: prdataNext[7:0] = capHiReg;
				`PT16_OFF_CAPTURE_LOW: prdataNext[7:0] = capLoReg;
				`PT16_OFF_EDGE_STATUS: prdataNext[1:0] = edgeFlagReg;
				default: pslverrNext = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shCtrlReg <= `PT16_RESET_BYTE;
			wCtrlReg <= 7'h00;
			timeoutReg <= 1'b0;
			reloadHiReg <= `PT16_RESET_BYTE;
			reloadLoReg <= `PT16_RESET_BYTE;
			capHiReg <= `PT16_RESET_BYTE;
			capLoReg <= `PT16_RESET_BYTE;
			edgeFlagReg <= 2'h0;
			countReg <= `PT16_RESET_COUNT;
			stateReg <= pt16_pkg::ST_IDLE;
			outReg <= 1'b0;
			rearmReg <= 1'b0;
			divReg <= 3'h0;
			prdataReg <= 32'h0000_0000;
			preadyReg <= 1'b0;
			pslverrReg <= 1'b0;
			narrowStartReg <= 1'b0;
			toIrqReg <= 1'b0;
			capIrqReg <= 1'b0;
			wideOutReg <= 1'b1;
			pinReg <= 1'b0;
		end else begin
			shCtrlReg <= shCtrlNext;
			wCtrlReg <= wCtrlNext;
			timeoutReg <= timeoutNext;
			reloadHiReg <= reloadHiNext;
			reloadLoReg <= reloadLoNext;
			capHiReg <= capHiNext;
			capLoReg <= capLoNext;
			edgeFlagReg <= edgeFlagNext;
			countReg <= countNext;
			stateReg <= stateNext;
			outReg <= outNext;
			rearmReg <= rearmNext;
			divReg <= divNext;
			prdataReg <= prdataNext;
			preadyReg <= preadyNext;
			pslverrReg <= pslverrNext;
			narrowStartReg <= narrowStartNext;
			toIrqReg <= toIrqNext;
			capIrqReg <= capIrqNext;
			wideOutReg <= wideOutNext;
			pinReg <= pinNext;
		end
	end

	assign prdata = prdataReg;
	assign pready = preadyReg;
	assign pslverr = pslverrReg;
	assign narrowStart = narrowStartReg;
	assign timeoutIrq = toIrqReg;
	assign captureIrq = capIrqReg;
	assign wideCounterOutput = wideOutReg;
	assign timerOutputPin = pinReg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	chk_idle_inverse: assert property ((stateReg == pt16_pkg::ST_IDLE && !outSel[1]) |->
		wideOutReg == ~initBit || $changed(shCtrlReg)) else $error("idle output wrong"); // RULE1
	chk_force_output: assert property ((outSel[1] && $stable(shCtrlReg)) |->
		wideOutReg == outSel[0]) else $error("forced output wrong"); // RULE2
	chk_enable_load: assert property ((stateReg == pt16_pkg::ST_IDLE && !demod &&
		wrAccess && paddr == `PT16_OFF_WIDE_CTRL && pwdata[7]) |=>
		countReg == $past(reloadValue) && outReg == $past(initBit)) else $error("no load"); // RULE3
	chk_terminal_flag: assert property ((stateReg == pt16_pkg::ST_RUN && !demod && tick &&
		countReg == `PT16_COUNT_ONE && !wrAccess) |=> timeoutReg && outReg != $past(outReg))
		else $error("terminal count missed"); // RULE4
	chk_single_stop: assert property ((stateReg == pt16_pkg::ST_RUN && !demod && tick &&
		countReg == `PT16_COUNT_ONE && ignoreEdges && !wrAccess) |=>
		stateReg == pt16_pkg::ST_IDLE) else $error("single pass kept running"); // RULE5
	chk_zero_wrap: assert property ((stateReg == pt16_pkg::ST_RUN && tick && !edgeHit &&
		!narrowTerminal && countReg == 16'h0000 && !wrAccess) |=>
		countReg == `PT16_COUNT_ALL_ONES && timeoutReg == $past(timeoutReg))
		else $error("zero wrap wrong"); // RULE8
	chk_edge_capture: assert property ((stateReg == pt16_pkg::ST_RUN && demod && edgeHit &&
		!ignoreEdges && !wrAccess) |=> {capHiReg, capLoReg} == ~$past(countReg) &&
		countReg == `PT16_COUNT_ALL_ONES && capIrqReg == $past(wCtrlReg[`PT16_WC_CAPMASK_BIT]))
		else $error("capture wrong"); // RULE11
	chk_flag_sticky: assert property ((timeoutReg && !(wrAccess &&
		paddr == `PT16_OFF_WIDE_CTRL && pwdata[5])) |=> timeoutReg)
		else $error("time-out flag lost"); // RULE20
	chk_pingpong_start: assert property ((stateReg == pt16_pkg::ST_IDLE && pingPong &&
		narrowTerminal && !wrAccess) |=> stateReg == pt16_pkg::ST_RUN)
		else $error("ping-pong restart missed"); // RULE16
	chk_bus_ready: assert property ((psel && !penable) |=> pready ##1 !pready)
		else $error("ready timing wrong");

	cov_modulo_reload: cover property (stateReg == pt16_pkg::ST_RUN && tick && !ignoreEdges
		&& !demod && countReg == `PT16_COUNT_ONE);
	cov_demod_capture: cover property (capIrqReg);
	cov_pingpong_handoff: cover property (narrowStartReg ##[1:1000] stateReg == pt16_pkg::ST_RUN);

endmodule

/* tb/pt16_pulse_source.sv */
`timescale 1ns/1ps

// ==========================================================
// Far side: pulse source on the input pin and the companion narrow counter.
module pt16_pulse_source #(
	parameter int PULSE_LEN = 8,
	parameter int NARROW_WAIT = 5
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic pulseReq,
	input wire logic tickReq,
	input wire logic narrowStart,
	output logic edgeIn,
	output logic narrowTerminal
);
	int holdCnt;
	int waitCnt;

	// The narrow counter answers a start only after its own run, never at once.
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			edgeIn <= 1'b0;
			narrowTerminal <= 1'b0;
			holdCnt <= 0;
			waitCnt <= 0;
		end else begin
			edgeIn <= pulseReq || holdCnt > 1;
			holdCnt <= pulseReq ? PULSE_LEN : (holdCnt > 0 ? holdCnt - 1 : 0);
			narrowTerminal <= tickReq || waitCnt == 1;
			waitCnt <= narrowStart ? NARROW_WAIT : (waitCnt > 0 ? waitCnt - 1 : 0);
		end
	end
endmodule

/* tb/pt16_timer_tb.sv */
`timescale 1ns/1ps
`include "pt16_params.svh"

module pt16_timer_tb;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic portOut = 1'b0;
	logic pulseReq = 1'b0;
	logic tickReq = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, edgeIn, narrowTerminal, narrowStart;
	logic timeoutIrq, captureIrq, wideCounterOutput, timerOutputPin;
	logic [7:0] rdat;
	logic rerr;
	logic lastIn = 1'b0;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	int toCnt = 0, toAt = 0, toGap = 0, capCnt = 0, nsCnt = 0, riseAt = 0, riseGap = 0;

	always #20 core_clk = ~core_clk;

	pt16_timer pt16_timer_i (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .edgeIn, .portOut, .narrowTerminal, .narrowStart,
		.timeoutIrq, .captureIrq, .wideCounterOutput, .timerOutputPin);

	pt16_pulse_source pt16_pulse_source_i (.core_clk, .nrst, .pulseReq, .tickReq,
		.narrowStart, .edgeIn, .narrowTerminal);

	// ==========================================================
	// Event monitor
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		lastIn <= edgeIn;
		if (edgeIn === 1'b1 && lastIn === 1'b0) begin
			riseGap <= cyc - riseAt;
			riseAt <= cyc;
		end
		if (timeoutIrq === 1'b1) begin
			toGap <= cyc - toAt;
			toAt <= cyc;
			toCnt <= toCnt + 1;
		end
		if (captureIrq === 1'b1)
			capCnt <= capCnt + 1;
		if (narrowStart === 1'b1)
			nsCnt <= nsCnt + 1;
	end

	// ==========================================================
	// Helpers
	task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rdat = prdata[7:0];
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task waitTo(input int k);
		int n;
		n = toCnt + k;
		repeat (400) if (toCnt < n) @(posedge core_clk);
		chk(toCnt >= n, 1'b1, "time-out missing");
	endtask

	task req(input logic tick, input int gap);
		@(posedge core_clk);
		tickReq <= tick;
		pulseReq <= !tick;
		@(posedge core_clk);
		tickReq <= 1'b0;
		pulseReq <= 1'b0;
		repeat (gap) @(posedge core_clk);
	endtask

	// ==========================================================
	// Scenarios
	task t_reset();
		chk(wideCounterOutput, 1'b1, "idle output");
		portOut <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(timerOutputPin, 1'b1, "port route");
		portOut <= 1'b0;
		apb(1'b0, `PT16_OFF_WIDE_CTRL, 8'h00);
		chk(rdat, 8'h00, "wide ctrl reset");
		apb(1'b0, 8'h1C, 8'h00);
		chk({rerr, rdat}, 9'h100, "unmapped read");
		$display("reset test done");
	endtask

	task t_single();
		int n;
		apb(1'b1, `PT16_OFF_RELOAD_HIGH, 8'h00);
		apb(1'b1, `PT16_OFF_RELOAD_LOW, 8'h05);
		apb(1'b1, `PT16_OFF_SHARED_CTRL, 8'h01);
		repeat (2) @(posedge core_clk);
		chk(wideCounterOutput, 1'b0, "idle inverse");
		n = toCnt;
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'hC3);
		repeat (2) @(posedge core_clk);
		chk(wideCounterOutput, 1'b1, "starts at init");
		chk(timerOutputPin, 1'b1, "pin shows wide output");
		repeat (20) @(posedge core_clk);
		chk(toCnt, n + 1, "one time-out");
		chk(wideCounterOutput, 1'b0, "output toggled");
		apb(1'b0, `PT16_OFF_WIDE_CTRL, 8'h00);
		chk(rdat, 8'h63, "stopped with flag");
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h43);
		apb(1'b0, `PT16_OFF_WIDE_CTRL, 8'h00);
		chk(rdat, 8'h63, "zero kept flag");
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h63);
		apb(1'b0, `PT16_OFF_WIDE_CTRL, 8'h00);
		chk(rdat, 8'h43, "one cleared flag");
		$display("single test done");
	endtask

	task t_modulo();
		int n;
		apb(1'b1, `PT16_OFF_SHARED_CTRL, 8'h00);
		apb(1'b1, `PT16_OFF_RELOAD_LOW, 8'h04);
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h82 | 8'(d << 3));
			waitTo(3);
			chk(toGap, 16'(4 << d), "period");
		end
		apb(1'b1, `PT16_OFF_RELOAD_LOW, 8'h06);
		waitTo(1);
		chk(toGap, 16'h0020, "old reload kept");
		waitTo(1);
		chk(toGap, 16'h0030, "new reload used");
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h00);
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h20);
		apb(1'b1, `PT16_OFF_RELOAD_LOW, 8'h00);
		n = toCnt;
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h82);
		repeat (60) @(posedge core_clk);
		chk(toCnt, n, "zero wraps quietly");
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h00);
		apb(1'b1, `PT16_OFF_SHARED_CTRL, 8'h08);
		repeat (2) @(posedge core_clk);
		chk(wideCounterOutput, 1'b0, "forced low");
		apb(1'b1, `PT16_OFF_SHARED_CTRL, 8'h0D);
		repeat (2) @(posedge core_clk);
		chk(wideCounterOutput, 1'b1, "forced high");
		$display("modulo test done");
	endtask

	task t_demod();
		logic [7:0] sel [3] = '{8'h10, 8'h20, 8'h30};
		logic [7:0] flags [3] = '{8'h02, 8'h01, 8'h03};
		int first [3] = '{0, 0, 1};
		int want [3] = '{1, 1, 3};
		int n;
		logic [15:0] cap;
		apb(1'b1, `PT16_OFF_RELOAD_HIGH, 8'hFF);
		apb(1'b1, `PT16_OFF_RELOAD_LOW, 8'hFF);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `PT16_OFF_SHARED_CTRL, 8'h40 | sel[i]);
			apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h84);
			n = capCnt;
			req(1'b0, 20);
			chk(capCnt, n + first[i], "first edge");
			req(1'b0, 20);
			chk(capCnt, n + want[i], "captures");
			apb(1'b0, `PT16_OFF_CAPTURE_HIGH, 8'h00);
			cap[15:8] = rdat;
			apb(1'b0, `PT16_OFF_CAPTURE_LOW, 8'h00);
			cap[7:0] = rdat;
			if (i == 0)
				chk(cap + 1 >= riseGap && cap <= riseGap + 1, 1'b1, "span");
			apb(1'b0, `PT16_OFF_EDGE_STATUS, 8'h00);
			chk(rdat, flags[i], "edge flags");
			apb(1'b1, `PT16_OFF_EDGE_STATUS, 8'h03);
			apb(1'b0, `PT16_OFF_EDGE_STATUS, 8'h00);
			chk(rdat, 8'h00, "flags cleared");
			apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h00);
		end
		$display("demod test done");
	endtask

	task t_ignore();
		int n;
		apb(1'b1, `PT16_OFF_SHARED_CTRL, 8'h50);
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'hC4);
		n = capCnt;
		req(1'b0, 20);
		req(1'b0, 20);
		chk(capCnt, n, "edges ignored");
		req(1'b1, 5);
		chk(capCnt, n + 1, "narrow capture");
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h84);
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'hC4);
		req(1'b0, 20);
		req(1'b0, 20);
		chk(capCnt, n + 2, "one rearmed edge");
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h00);
		apb(1'b1, `PT16_OFF_SHARED_CTRL, 8'h00);
		$display("ignore test done");
	endtask

	task t_pingpong();
		int n;
		int t;
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'h20);
		apb(1'b1, `PT16_OFF_EDGE_STATUS, 8'h03);
		apb(1'b1, `PT16_OFF_RELOAD_HIGH, 8'h00);
		apb(1'b1, `PT16_OFF_RELOAD_LOW, 8'h03);
		apb(1'b1, `PT16_OFF_SHARED_CTRL, 8'h04);
		n = nsCnt;
		t = toCnt;
		apb(1'b1, `PT16_OFF_WIDE_CTRL, 8'hC2);
		repeat (40) @(posedge core_clk);
		chk(nsCnt - n >= 3, 1'b1, "counters alternate");
		chk(toCnt - t, nsCnt - n, "flag per terminal");
		apb(1'b1, `PT16_OFF_SHARED_CTRL, 8'h00);
		repeat (20) @(posedge core_clk);
		n = nsCnt;
		repeat (60) @(posedge core_clk);
		chk(nsCnt, n, "ping-pong ended");
		$display("ping-pong test done");
	endtask

	// ==========================================================
	// Run control
	task conclude();
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge core_clk);
		t_reset();
		t_single();
		t_modulo();
		t_demod();
		t_ignore();
		t_pingpong();
		conclude();
	end

	// Generous margin over the roughly one thousand cycles the tests need.
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		conclude();
	end
endmodule
